// *** verilog/dfm_defines.vh ***
// Overview of operation
// - Any fault stops the drive; each fault is type 1 or type 2.
// - Type 1 fault with nonzero attempt limit and nonzero delay loads the restart delay countdown while attempts used stay below the limit.
// - Countdown reaching zero starts an automatic reset attempt, no operator needed.
// - Automatic attempt clears and restarts only if the cause has gone.
// - Type 2 faults never auto-reset; clears refused while the cause persists.
// - Auto restart does fault reset then issues the drive's own start command.
// - Nonzero limit with zero delay clears F4, F5, F8 without restarting.
// - Active fault shows flashing fault number and flashing fault indicator.
// - Escape key acknowledges, blanks the flashing display, does not clear fault.
// - Most recent fault code kept in a readable latest fault code slot.
// - Keypad stop clears a correctable fault only when stop behaviour is 0..3.
// - Writing 1 or 2 to fault clear request clears a correctable fault.
// - Toggling a digital input whose function select is 7 clears a fault.
// - Open aux interlock raises F2 type 1; bus ripple raises F3 type 2.
// - Bus undervoltage raises F4, overvoltage raises F5; both type 1.
// - Failure to accelerate the motor raises F6, motor stalled.
// - Attempts failing for the full limit raise F33, type 2, manual clear.
`ifndef DFM_DEFINES_VH
`define DFM_DEFINES_VH

`define DFM_CLK_KHZ          20000
`define DFM_DELAY_UNIT_MS    100
`define DFM_FLASH_HALF_MS    500
`define DFM_DELAY_TICK_CYC   (`DFM_DELAY_UNIT_MS * `DFM_CLK_KHZ)
`define DFM_FLASH_HALF_CYC   (`DFM_FLASH_HALF_MS * `DFM_CLK_KHZ)

`define DFM_ADDR_LIMIT       6'h00
`define DFM_ADDR_DELAY       6'h04
`define DFM_ADDR_STOPSEL     6'h08
`define DFM_ADDR_CLEAR       6'h0c
`define DFM_ADDR_DINFUNC     6'h10
`define DFM_ADDR_STATUS      6'h14
`define DFM_ADDR_CODE        6'h18
`define DFM_ADDR_IRQSTS      6'h1c
`define DFM_ADDR_IRQMASK     6'h20

`define DFM_ST_ACTIVE        0
`define DFM_ST_TYPE2         1
`define DFM_ST_ACKED         2
`define DFM_ST_CODE_LSB      8
`define DFM_ST_TRIES_LSB     16

`define DFM_IRQ_FAULT        0
`define DFM_IRQ_AUTOCLR      1
`define DFM_IRQ_RESTART      2
`define DFM_IRQ_EXHAUST      3
`define DFM_IRQ_W            4

`define DFM_CODE_NONE        8'h00
`define DFM_CODE_AUX         8'h02
`define DFM_CODE_RIPPLE      8'h03
`define DFM_CODE_UNDERV      8'h04
`define DFM_CODE_OVERV       8'h05
`define DFM_CODE_STALL       8'h06
`define DFM_CODE_HEAT        8'h08
`define DFM_CODE_TRIES       8'h21

`define DFM_CLR_VAL_A        8'h01
`define DFM_CLR_VAL_B        8'h02
`define DFM_STOPSEL_MAX      8'h03
`define DFM_DIN_CLEAR_FUNC   8'h07

`define DFM_CI_AUX           0
`define DFM_CI_RIPPLE        1
`define DFM_CI_UNDERV        2
`define DFM_CI_OVERV         3
`define DFM_CI_STALL         4
`define DFM_CI_HEAT          5
`define DFM_NCOND            6

`endif

// *** verilog/dfm_sync.v ***
`timescale 1ns/1ps
module dfm_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// *** verilog/dfm_fault_mgr.v ***
`timescale 1ns/1ps
`include "dfm_defines.vh"
module dfm_fault_mgr #(
  parameter NUM_DIN           = 4,
  parameter DELAY_TICK_CYCLES = `DFM_DELAY_TICK_CYC,
  parameter FLASH_HALF_CYCLES = `DFM_FLASH_HALF_CYC
) (
  input  wire                 CLK_SYS,
  input  wire                 RESETN,
  input  wire [5:0]           AVS_ADDRESS,
  input  wire                 AVS_READ,
  input  wire                 AVS_WRITE,
  input  wire [31:0]          AVS_WRITEDATA,
  output wire [31:0]          AVS_READDATA,
  output wire                 AVS_WAITREQUEST,
  input  wire                 AUX_INTERLOCK_OPEN,
  input  wire                 BUS_RIPPLE_HIGH,
  input  wire                 BUS_UNDERVOLT,
  input  wire                 BUS_OVERVOLT,
  input  wire                 MOTOR_STALL,
  input  wire                 HEATSINK_OVERTEMP,
  input  wire                 KEY_STOP,
  input  wire                 KEY_ESC,
  input  wire [NUM_DIN-1:0]   DIG_IN,
  output wire                 DRIVE_STOP,
  output wire                 DRIVE_START,
  output wire                 FAULT_ACTIVE,
  output wire                 FAULT_NONRESETTABLE,
  output wire [7:0]           DISP_FAULT_CODE,
  output wire                 DISP_FAULT_IND,
  output wire                 IRQ
);

  localparam ST_OK    = 4'b0001;
  localparam ST_FAULT = 4'b0010;
  localparam ST_DELAY = 4'b0100;
  localparam ST_TRY   = 4'b1000;

  localparam NSYNC = `DFM_NCOND + 2 + NUM_DIN;

  // Pin synchronisation
  wire [NSYNC-1:0] pins_s;
  dfm_sync #(
    .W (NSYNC)
  ) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .d     ({DIG_IN, KEY_ESC, KEY_STOP, HEATSINK_OVERTEMP, MOTOR_STALL,
             BUS_OVERVOLT, BUS_UNDERVOLT, BUS_RIPPLE_HIGH, AUX_INTERLOCK_OPEN}),
    .q     (pins_s)
  );

  wire [`DFM_NCOND-1:0] cond  = pins_s[`DFM_NCOND-1:0];
  wire                  stop_s = pins_s[`DFM_NCOND];
  wire                  esc_s  = pins_s[`DFM_NCOND+1];
  wire [NUM_DIN-1:0]    din_s  = pins_s[NSYNC-1:`DFM_NCOND+2];

  reg                   stop_prev_q;
  reg                   esc_prev_q;
  reg [NUM_DIN-1:0]     din_prev_q;

  // Settings and state
  reg [7:0]             limit_q;
  reg [15:0]            delay_q;
  reg [7:0]             stopsel_q;
  reg [8*NUM_DIN-1:0]   din_func_q;
  reg [`DFM_IRQ_W-1:0]  irq_sts_q;
  reg [`DFM_IRQ_W-1:0]  irq_mask_q;
  reg [3:0]             state_q;
  reg [3:0]             state_d;
  reg [7:0]             code_q;
  reg [7:0]             code_d;
  reg [7:0]             orig_q;
  reg [7:0]             orig_d;
  reg [7:0]             tries_q;
  reg [7:0]             tries_d;
  reg [15:0]            dcnt_q;
  reg [15:0]            dcnt_d;
  reg [23:0]            tick_q;
  reg [23:0]            tick_d;
  reg                   acked_q;
  reg                   acked_d;
  reg                   start_q;
  reg                   start_d;
  reg [23:0]            flash_cnt_q;
  reg                   flash_q;
  reg [7:0]             disp_code_q;
  reg                   disp_ind_q;
  reg                   bus_ack_q;
  reg [31:0]            rdata_q;
  reg [31:0]            rdata_d;
  reg                   ev_fault;
  reg                   ev_autoclr;
  reg                   ev_restart;
  reg                   ev_exhaust;
  reg                   din_clr;
  integer               i;

  // Bus handshake: one wait cycle, then the access completes
  wire req     = AVS_READ | AVS_WRITE;
  wire wr_en   = AVS_WRITE & bus_ack_q;
  wire rd_en   = AVS_READ & bus_ack_q;
  wire [5:0] wa = {AVS_ADDRESS[5:2], 2'b00};

  assign AVS_WAITREQUEST = req & ~bus_ack_q;
  assign AVS_READDATA    = rdata_q;

  function cause_on;
    input [7:0]            code;
    input [`DFM_NCOND-1:0] c;
    begin
      case (code)
        `DFM_CODE_AUX:    cause_on = c[`DFM_CI_AUX];
        `DFM_CODE_RIPPLE: cause_on = c[`DFM_CI_RIPPLE];
        `DFM_CODE_UNDERV: cause_on = c[`DFM_CI_UNDERV];
        `DFM_CODE_OVERV:  cause_on = c[`DFM_CI_OVERV];
        `DFM_CODE_STALL:  cause_on = c[`DFM_CI_STALL];
        `DFM_CODE_HEAT:   cause_on = c[`DFM_CI_HEAT];
        default:          cause_on = 1'b0;
      endcase
    end
  endfunction

  function is_type2;
    input [7:0] code;
    begin
      is_type2 = (code == `DFM_CODE_RIPPLE) || (code == `DFM_CODE_TRIES);
    end
  endfunction

  // Type 2 checked first so it is never masked by a resettable one
  reg [7:0] new_code;
  always @* begin
    new_code = `DFM_CODE_NONE;
    if (cond[`DFM_CI_RIPPLE])
      new_code = `DFM_CODE_RIPPLE;
    else if (cond[`DFM_CI_AUX])
      new_code = `DFM_CODE_AUX;
    else if (cond[`DFM_CI_UNDERV])
      new_code = `DFM_CODE_UNDERV;
    else if (cond[`DFM_CI_OVERV])
      new_code = `DFM_CODE_OVERV;
    else if (cond[`DFM_CI_STALL])
      new_code = `DFM_CODE_STALL;
    else if (cond[`DFM_CI_HEAT])
      new_code = `DFM_CODE_HEAT;
  end

  always @* begin
    din_clr = 1'b0;
    for (i = 0; i < NUM_DIN; i = i + 1) begin
      if ((din_s[i] != din_prev_q[i]) &&
          (din_func_q[i*8 +: 8] == `DFM_DIN_CLEAR_FUNC))
        din_clr = 1'b1;
    end
  end

  wire stop_clr = stop_s & ~stop_prev_q & (stopsel_q <= `DFM_STOPSEL_MAX);
  wire wr_clr   = wr_en & (wa == `DFM_ADDR_CLEAR) &
                  ((AVS_WRITEDATA[7:0] == `DFM_CLR_VAL_A) ||
                   (AVS_WRITEDATA[7:0] == `DFM_CLR_VAL_B));
  wire clr_req  = stop_clr | wr_clr | din_clr;
  wire esc_edge = esc_s & ~esc_prev_q;
  wire tick_end = (tick_q == DELAY_TICK_CYCLES - 1);
  wire zero_dly = (delay_q == 16'h0000);
  wire fast_clr = (code_d == `DFM_CODE_UNDERV) || (code_d == `DFM_CODE_OVERV) ||
                  (code_d == `DFM_CODE_HEAT);

  // Fault sequencer
  always @* begin
    state_d    = state_q;
    code_d     = code_q;
    orig_d     = orig_q;
    tries_d    = tries_q;
    dcnt_d     = dcnt_q;
    tick_d     = tick_q;
    acked_d    = acked_q;
    start_d    = 1'b0;
    ev_fault   = 1'b0;
    ev_autoclr = 1'b0;
    ev_restart = 1'b0;
    ev_exhaust = 1'b0;
    if (esc_edge && state_q != ST_OK)
      acked_d = 1'b1;
    case (state_q)
      ST_OK: begin
        if (|cond) begin
          code_d   = new_code;
          orig_d   = new_code;
          acked_d  = 1'b0;
          ev_fault = 1'b1;
          state_d  = ST_FAULT;
          if (!is_type2(new_code) && limit_q != 8'h00) begin
            if (tries_q >= limit_q) begin
              code_d     = `DFM_CODE_TRIES;
              ev_exhaust = 1'b1;
            end else if (zero_dly) begin
              if (fast_clr)
                state_d = ST_TRY;
            end else begin
              state_d = ST_DELAY;
              dcnt_d  = delay_q;
              tick_d  = 24'h000000;
            end
          end
        end
      end
      ST_DELAY: begin
        if (clr_req && !cause_on(orig_q, cond)) begin
          state_d = ST_OK;
          tries_d = 8'h00;
        end else if (tick_end) begin
          tick_d = 24'h000000;
          dcnt_d = dcnt_q - 16'h0001;
          if (dcnt_q == 16'h0001)
            state_d = ST_TRY;
        end else begin
          tick_d = tick_q + 24'h000001;
        end
      end
      ST_TRY: begin
        tries_d = zero_dly ? tries_q : tries_q + 8'h01;
        if (!cause_on(orig_q, cond)) begin
          state_d    = ST_OK;
          ev_autoclr = 1'b1;
          if (!zero_dly) begin
            start_d    = 1'b1;
            ev_restart = 1'b1;
          end
        end else if (zero_dly) begin
          state_d = ST_TRY;
        end else if (tries_d >= limit_q) begin
          state_d    = ST_FAULT;
          code_d     = `DFM_CODE_TRIES;
          acked_d    = 1'b0;
          ev_exhaust = 1'b1;
        end else begin
          state_d = ST_DELAY;
          dcnt_d  = delay_q;
          tick_d  = 24'h000000;
        end
      end
      ST_FAULT: begin
        if (clr_req && !cause_on(orig_q, cond)) begin
          state_d = ST_OK;
          tries_d = 8'h00;
        end
      end
      default: state_d = ST_FAULT;
    endcase
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_q     <= ST_OK;
      code_q      <= `DFM_CODE_NONE;
      orig_q      <= `DFM_CODE_NONE;
      tries_q     <= 8'h00;
      dcnt_q      <= 16'h0000;
      tick_q      <= 24'h000000;
      acked_q     <= 1'b0;
      start_q     <= 1'b0;
      stop_prev_q <= 1'b0;
      esc_prev_q  <= 1'b0;
      din_prev_q  <= {NUM_DIN{1'b0}};
    end else begin
      state_q     <= state_d;
      code_q      <= code_d;
      orig_q      <= orig_d;
      tries_q     <= tries_d;
      dcnt_q      <= dcnt_d;
      tick_q      <= tick_d;
      acked_q     <= acked_d;
      start_q     <= start_d;
      stop_prev_q <= stop_s;
      esc_prev_q  <= esc_s;
      din_prev_q  <= din_s;
    end
  end

  assign DRIVE_STOP          = (state_q != ST_OK);
  assign DRIVE_START         = start_q;
  assign FAULT_ACTIVE        = (state_q != ST_OK);
  assign FAULT_NONRESETTABLE = (state_q != ST_OK) && is_type2(code_q);

  // Keypad flashing
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      flash_cnt_q <= 24'h000000;
      flash_q     <= 1'b0;
      disp_code_q <= `DFM_CODE_NONE;
      disp_ind_q  <= 1'b0;
    end else begin
      if (flash_cnt_q == FLASH_HALF_CYCLES - 1) begin
        flash_cnt_q <= 24'h000000;
        flash_q     <= ~flash_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 24'h000001;
      end
      if (state_q != ST_OK && !acked_q && flash_q) begin
        disp_code_q <= code_q;
        disp_ind_q  <= 1'b1;
      end else begin
        disp_code_q <= `DFM_CODE_NONE;
        disp_ind_q  <= 1'b0;
      end
    end
  end

  assign DISP_FAULT_CODE = disp_code_q;
  assign DISP_FAULT_IND  = disp_ind_q;

  // Read data sampled in the wait cycle
  always @* begin
    rdata_d = 32'h00000000;
    case (wa)
      `DFM_ADDR_LIMIT:   rdata_d[7:0]  = limit_q;
      `DFM_ADDR_DELAY:   rdata_d[15:0] = delay_q;
      `DFM_ADDR_STOPSEL: rdata_d[7:0]  = stopsel_q;
      `DFM_ADDR_DINFUNC: rdata_d[8*NUM_DIN-1:0] = din_func_q;
      `DFM_ADDR_STATUS: begin
        rdata_d[`DFM_ST_ACTIVE] = (state_q != ST_OK);
        rdata_d[`DFM_ST_TYPE2]  = FAULT_NONRESETTABLE;
        rdata_d[`DFM_ST_ACKED]  = acked_q;
        rdata_d[`DFM_ST_CODE_LSB +: 8]  = code_q;
        rdata_d[`DFM_ST_TRIES_LSB +: 8] = tries_q;
      end
      `DFM_ADDR_CODE:    rdata_d[7:0] = code_q;
      `DFM_ADDR_IRQSTS:  rdata_d[`DFM_IRQ_W-1:0] = irq_sts_q;
      `DFM_ADDR_IRQMASK: rdata_d[`DFM_IRQ_W-1:0] = irq_mask_q;
      default:           rdata_d = 32'h00000000;
    endcase
  end

  // Events caught between sampling and clearing survive the read
  wire [`DFM_IRQ_W-1:0] ev_vec = {ev_exhaust, ev_restart, ev_autoclr, ev_fault};
  wire [`DFM_IRQ_W-1:0] rd_clr = (rd_en && wa == `DFM_ADDR_IRQSTS) ?
                                 rdata_q[`DFM_IRQ_W-1:0] : {`DFM_IRQ_W{1'b0}};

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      bus_ack_q  <= 1'b0;
      rdata_q    <= 32'h00000000;
      limit_q    <= 8'h00;
      delay_q    <= 16'h0000;
      stopsel_q  <= 8'h00;
      din_func_q <= {8*NUM_DIN{1'b0}};
      irq_sts_q  <= {`DFM_IRQ_W{1'b0}};
      irq_mask_q <= {`DFM_IRQ_W{1'b0}};
    end else begin
      bus_ack_q <= req & ~bus_ack_q;
      if (AVS_READ && !bus_ack_q)
        rdata_q <= rdata_d;
      irq_sts_q <= (irq_sts_q & ~rd_clr) | ev_vec;
      if (wr_en) begin
        case (wa)
          `DFM_ADDR_LIMIT:   limit_q    <= AVS_WRITEDATA[7:0];
          `DFM_ADDR_DELAY:   delay_q    <= AVS_WRITEDATA[15:0];
          `DFM_ADDR_STOPSEL: stopsel_q  <= AVS_WRITEDATA[7:0];
          `DFM_ADDR_DINFUNC: din_func_q <= AVS_WRITEDATA[8*NUM_DIN-1:0];
          `DFM_ADDR_IRQMASK: irq_mask_q <= AVS_WRITEDATA[`DFM_IRQ_W-1:0];
          default:           limit_q    <= limit_q;
        endcase
      end
    end
  end
  assign IRQ = |(irq_sts_q & irq_mask_q);

endmodule

// *** sim/dfm_field.sv ***
`timescale 1ns/1ps
module dfm_field (
  input  wire logic       clk,
  input  wire logic [5:0] cond_req,
  input  wire logic [1:0] key_req,
  input  wire logic [3:0] din_req,
  output logic      [5:0] cond_q = 6'h00,
  output logic      [1:0] key_q  = 2'h0,
  output logic      [3:0] din_q  = 4'h0
);
  // Detector levels settle one edge after the request, never mid-cycle
  always @(posedge clk) begin
    cond_q <= cond_req;
    key_q  <= key_req;
    din_q  <= din_req;
  end
endmodule

// *** sim/dfm_fault_mgr_asserts.sv ***
`timescale 1ns/1ps
module dfm_fault_mgr_asserts (
  input wire logic       CLK_SYS,
  input wire logic       RESETN,
  input wire logic       AVS_READ,
  input wire logic       AVS_WRITE,
  input wire logic       AVS_WAITREQUEST,
  input wire logic       AUX_INTERLOCK_OPEN,
  input wire logic       BUS_RIPPLE_HIGH,
  input wire logic       BUS_UNDERVOLT,
  input wire logic       BUS_OVERVOLT,
  input wire logic       MOTOR_STALL,
  input wire logic       HEATSINK_OVERTEMP,
  input wire logic       KEY_STOP,
  input wire logic       KEY_ESC,
  input wire logic       DRIVE_STOP,
  input wire logic       DRIVE_START,
  input wire logic       FAULT_ACTIVE,
  input wire logic       FAULT_NONRESETTABLE,
  input wire logic [7:0] DISP_FAULT_CODE,
  input wire logic       DISP_FAULT_IND
);
  wire [5:0] conds;
  assign conds = {HEATSINK_OVERTEMP, MOTOR_STALL, BUS_OVERVOLT, BUS_UNDERVOLT,
                  BUS_RIPPLE_HIGH, AUX_INTERLOCK_OPEN};
  default clocking dck @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  AST_STOP_WITH_FAULT: assert property ($rose(conds != 6'h00) |-> ##[1:4] DRIVE_STOP)
    else $error("drive not stopped after a fault condition");
  // Two sync flops plus the latch edge, one cycle of slack either side
  AST_FAULT_HAS_CAUSE: assert property ($rose(FAULT_ACTIVE) |->
    ($past(conds, 2) != 6'h00) || ($past(conds, 3) != 6'h00) || ($past(conds, 4) != 6'h00))
    else $error("fault latched with no condition present");
  AST_START_ONE_CYCLE: assert property (DRIVE_START |=> !DRIVE_START)
    else $error("start command longer than one cycle");
  AST_START_AFTER_RESET: assert property (DRIVE_START |-> !FAULT_ACTIVE &&
    ($past(FAULT_ACTIVE, 1) || $past(FAULT_ACTIVE, 2)))
    else $error("start command not right after a fault reset");
  AST_TYPE2_IS_FAULT: assert property (FAULT_NONRESETTABLE |-> FAULT_ACTIVE)
    else $error("non-resettable flag without fault");
  AST_IND_NEEDS_FAULT: assert property (DISP_FAULT_IND |-> $past(FAULT_ACTIVE))
    else $error("fault indicator lit without fault");
  AST_CODE_WITH_IND: assert property ((DISP_FAULT_CODE != 8'h00) == DISP_FAULT_IND)
    else $error("fault number and indicator flash out of step");
  AST_ESC_KEEPS_FAULT: assert property ($rose(KEY_ESC) && FAULT_ACTIVE && !KEY_STOP |->
    FAULT_ACTIVE [*6])
    else $error("escape key cleared the fault");
  AST_ONE_WAIT_CYCLE: assert property ($rose(AVS_READ || AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus answer not after exactly one wait cycle");
  COV_RESTART: cover property ($rose(DRIVE_START));
  COV_EXHAUST: cover property ($rose(FAULT_NONRESETTABLE));
  COV_ACK: cover property ($fell(DISP_FAULT_IND) && FAULT_ACTIVE);
endmodule
bind dfm_fault_mgr dfm_fault_mgr_asserts dfm_fault_mgr_asserts_i (.*);

// *** sim/test_dfm_fault_mgr.sv ***
`timescale 1ns/1ps
`include "dfm_defines.vh"
module test_dfm_fault_mgr;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [5:0]  adr = 6'h00, cond = 6'h00;
  logic [31:0] wd = 32'h0, r;
  logic [1:0]  key = 2'h0;
  logic [3:0]  din = 4'h0;
  logic [63:0] ent, rq[$];
  logic [7:0]  codes [6] = '{`DFM_CODE_AUX, `DFM_CODE_RIPPLE, `DFM_CODE_UNDERV,
                             `DFM_CODE_OVERV, `DFM_CODE_STALL, `DFM_CODE_HEAT};
  int          zd [3] = '{`DFM_CI_UNDERV, `DFM_CI_OVERV, `DFM_CI_HEAT};
  wire [31:0]  rdat;
  wire [7:0]   dcode;
  wire [5:0]   cp;
  wire [1:0]   kp;
  wire [3:0]   dp;
  wire         wreq, sta, fa, fn, ind, irq, dstop;
  int          miscompares = 0, checked = 0, starts = 0, i, acc, seed = 32'hd047;
  always #25 clk = ~clk;
  dfm_field dfm_field_i (.clk(clk), .cond_req(cond), .key_req(key), .din_req(din),
    .cond_q(cp), .key_q(kp), .din_q(dp));
  dfm_fault_mgr #(.DELAY_TICK_CYCLES(4), .FLASH_HALF_CYCLES(8)) dfm_fault_mgr_i (
    .CLK_SYS(clk), .RESETN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .AUX_INTERLOCK_OPEN(cp[0]), .BUS_RIPPLE_HIGH(cp[1]), .BUS_UNDERVOLT(cp[2]),
    .BUS_OVERVOLT(cp[3]), .MOTOR_STALL(cp[4]), .HEATSINK_OVERTEMP(cp[5]),
    .KEY_STOP(kp[0]), .KEY_ESC(kp[1]), .DIG_IN(dp), .DRIVE_STOP(dstop), .DRIVE_START(sta),
    .FAULT_ACTIVE(fa), .FAULT_NONRESETTABLE(fn), .DISP_FAULT_CODE(dcode),
    .DISP_FAULT_IND(ind), .IRQ(irq));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reads note expected data and mask; the monitor compares at completion
  task bus(input bit w, input [5:0] a, input [31:0] d, input [31:0] m);
    int n;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    if (!w) rq.push_back({d, m});
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        miscompares++;
        end_of_test();
      end
    end while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rd === 1'b1 && wreq === 1'b0) begin
      ent = rq.pop_front();
      chk("readdata", ent[63:32] & ent[31:0], rdat & ent[31:0]);
    end
  end
  always @(posedge clk) if (sta === 1'b1) starts <= starts + 1;
  task wt(input int s, input bit v, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(negedge clk);
      if ((s == 0 ? fa : (s == 1 ? ind : fn)) === v) return;
    end
    miscompares++;
    $display("CHECK FAILED wait %0d exp %0d got timeout", s, v);
    end_of_test();
  endtask
  task chkfa(input bit e);
    @(negedge clk);
    chk("fault_active", e, fa);
    chk("drive_stop", e, dstop);
  endtask
  task press(input int k);
    @(posedge clk);
    key[k] <= 1'b1;
    cyc(4);
    key[k] <= 1'b0;
    cyc(6);
  endtask
  task setc(input int k, input bit v);
    @(posedge clk);
    cond[k] <= v;
  endtask
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    for (i = 0; i < 16; i++) bus(0, 6'(i * 4), 32'h0, 32'hffffffff);
    r = $random(seed);
    bus(1, `DFM_ADDR_STOPSEL, r, 32'h0);
    bus(0, `DFM_ADDR_STOPSEL, r & 32'hff, 32'hffffffff);
    bus(1, `DFM_ADDR_STOPSEL, 32'h3, 32'h0);
    bus(1, `DFM_ADDR_DINFUNC, 32'h700, 32'h0);
    for (i = 0; i < 6; i++) begin
      setc(i, 1'b1);
      wt(0, 1'b1, 20);
      chk("nonresettable", i == `DFM_CI_RIPPLE, fn);
      bus(0, `DFM_ADDR_STATUS, {16'h0, codes[i], 6'h0, i == 1, 1'b1}, 32'hff03);
      bus(0, `DFM_ADDR_CODE, codes[i], 32'hff);
      if (i == 0) begin
        @(negedge clk);
        chk("irq", 0, irq);
        bus(1, `DFM_ADDR_IRQMASK, 32'h1, 32'h0);
        @(negedge clk);
        chk("irq", 1, irq);
        bus(0, `DFM_ADDR_IRQSTS, 32'h1, 32'h1);
        @(negedge clk);
        chk("irq", 0, irq);
      end
      bus(1, `DFM_ADDR_CLEAR, 32'h1, 32'h0);
      chkfa(1'b1);
      setc(i, 1'b0);
      cyc(4);
      case (i % 3)
        0: press(0);
        1: bus(1, `DFM_ADDR_CLEAR, 32'h2, 32'h0);
        default: din[1] <= ~din[1];
      endcase
      wt(0, 1'b0, 20);
      bus(0, `DFM_ADDR_CODE, codes[i], 32'hff);
    end
    // Stop select above 3 and a toggle on a non-clearing input both do nothing
    setc(`DFM_CI_AUX, 1'b1);
    wt(0, 1'b1, 20);
    setc(`DFM_CI_AUX, 1'b0);
    r = $random(seed);
    bus(1, `DFM_ADDR_STOPSEL, {24'h0, r[7:0] | 8'h04}, 32'h0);
    press(0);
    din[0] <= ~din[0];
    cyc(6);
    chkfa(1'b1);
    bus(1, `DFM_ADDR_STOPSEL, 32'h3, 32'h0);
    press(0);
    wt(0, 1'b0, 20);
    bus(1, `DFM_ADDR_LIMIT, 32'h2, 32'h0);
    bus(1, `DFM_ADDR_DELAY, 32'h3, 32'h0);
    setc(`DFM_CI_AUX, 1'b1);
    wt(0, 1'b1, 20);
    setc(`DFM_CI_AUX, 1'b0);
    cyc(4);
    chkfa(1'b1);
    wt(0, 1'b0, 60);
    cyc(2);
    chk("starts", 1, starts);
    bus(0, `DFM_ADDR_STATUS, 32'h10000, 32'hff0001);
    setc(`DFM_CI_AUX, 1'b1);
    wt(2, 1'b1, 80);
    bus(0, `DFM_ADDR_STATUS, 32'h022103, 32'hffff07);
    bus(0, `DFM_ADDR_IRQSTS, 32'h8, 32'h8);
    cyc(40);
    press(0);
    chkfa(1'b1);
    chk("starts", 1, starts);
    setc(`DFM_CI_AUX, 1'b0);
    cyc(4);
    bus(1, `DFM_ADDR_CLEAR, 32'h1, 32'h0);
    wt(0, 1'b0, 20);
    bus(0, `DFM_ADDR_STATUS, 32'h0, 32'hff0001);
    bus(1, `DFM_ADDR_LIMIT, 32'h5, 32'h0);
    bus(1, `DFM_ADDR_DELAY, 32'h0, 32'h0);
    for (i = 0; i < 3; i++) begin
      setc(zd[i], 1'b1);
      wt(0, 1'b1, 20);
      setc(zd[i], 1'b0);
      wt(0, 1'b0, 40);
    end
    chk("starts", 1, starts);
    setc(`DFM_CI_STALL, 1'b1);
    wt(0, 1'b1, 20);
    setc(`DFM_CI_STALL, 1'b0);
    cyc(30);
    chkfa(1'b1);
    wt(1, 1'b1, 40);
    chk("disp_code", `DFM_CODE_STALL, dcode);
    press(1);
    acc = 0;
    repeat (30) @(negedge clk) acc = acc | ind;
    chk("flash_after_esc", 0, acc);
    bus(0, `DFM_ADDR_STATUS, 32'h0605, 32'hff07);
    din[1] <= ~din[1];
    wt(0, 1'b0, 20);
    end_of_test();
  end
endmodule
